/* tb/serial_rx_partner.sv */
// Receiver partner: samples the line at mid-bit and counts frames.
// Assumes the bench gives the bit period and word length.
`default_nettype none
module serial_rx_partner (
	input wire logic clk,
	input wire logic tx_line,
	input wire logic [5:0] p,
	input wire logic nine,
	output var logic [8:0] word,
	output var int cnt,
	output var int gap
);
	timeunit 1ns;
	timeprecision 1ps;
	real last;
	// Each start edge is timed, then every data bit is taken at its middle.
	initial
	begin
		cnt = 0;
		gap = 0;
		last = 0.0;
		word = '0;
		forever
		begin
			@(negedge tx_line);
			gap = int'(($realtime - last) / 5.0);
			last = $realtime;
			word = '0;
			repeat (p / 2) @(posedge clk);
			for (int k = 0; k < (nine ? 9 : 8); k++)
			begin
				repeat (p) @(posedge clk);
				word[k] = tx_line;
			end
			cnt++;
		end
	end
endmodule
`default_nettype wire

/* tb/serial_tx_checker.sv */
// Checker for the serial transmitter ports.
// Assumes it is bound to the design top and sees only its ports.
`include "serial_tx_cfg.svh"
`default_nettype none
module serial_tx_checker (
	input wire logic clk,
	input wire logic rst,
	input wire serial_tx_pkg::bus_req_s bus,
	input wire logic [31:0] rdata,
	input wire logic tx_line,
	input wire logic serial_clock_out,
	input wire logic tx_complete_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import serial_tx_pkg::*;
	logic tx_complete_irq_en;
	logic [15:0] baud;
	logic next_tx_complete_irq_en;
	logic [15:0] next_baud;
	// Shadow of the interrupt enable and divider, as written by software.
	always_comb
	begin
		next_tx_complete_irq_en = tx_complete_irq_en;
		next_baud = baud;
		if (bus.wr && bus.addr == `OFS_CTL_A)
			next_tx_complete_irq_en = bus.wdata[`CA_TX_COMPLETE_IRQ_EN];
		if (bus.wr && bus.addr == `OFS_BAUD)
			next_baud = bus.wdata[15:0];
	end
	// Shadow registers.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_complete_irq_en <= 1'b0;
			baud <= `BAUD_RST;
		end
		else
		begin
			tx_complete_irq_en <= next_tx_complete_irq_en;
			baud <= next_baud;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_data_wr;
		bus.wr && bus.addr == `OFS_DATA;
	endsequence
	sequence s_stat_rd;
		bus.rd && bus.addr == `OFS_STAT;
	endsequence
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data not idle");
	a_unmapped_read: assert property (bus.rd && bus.addr == 8'h20 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_baud_read: assert property (bus.rd && bus.addr == `OFS_BAUD |=>
		rdata == {16'h0, $past(baud)}) else $error("divider readback");
	a_tbe_load: assert property (s_data_wr ##1 s_stat_rd |=> !rdata[`ST_TBE])
		else $error("empty flag after write");
	a_irq_gate: assert property (!tx_complete_irq_en |-> !tx_complete_irq)
		else $error("irq while disabled");
	a_irq_stat: assert property (s_stat_rd and tx_complete_irq_en |=>
		rdata[`ST_TC] == $past(tx_complete_irq)) else $error("irq differs from flag");
	a_start_low: assert property ($fell(tx_line) |-> !tx_line [*8])
		else $error("low bit too short");
	a_ck_half: assert property ($rose(serial_clock_out) |-> serial_clock_out [*8])
		else $error("clock pulse too short");
endmodule
bind serial_transmit_frame_baud serial_tx_checker i_chk (.clk(clk), .rst(rst), .bus(bus),
	.rdata(rdata), .tx_line(tx_line), .serial_clock_out(serial_clock_out),
	.tx_complete_irq(tx_complete_irq));
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the serial transmitter with a reference queue of frames.
// Assumes the receiver partner and the bound checker.
`include "serial_tx_cfg.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import serial_tx_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	bus_req_s bus = '0;
	logic [31:0] rdata;
	logic tx_line;
	logic sclk;
	logic irq;
	logic [5:0] p = 6'h10;
	logic nine = 1'b0;
	logic [8:0] word;
	int rx_cnt;
	int gap;
	int error_cnt = 0;
	int check_count = 0;
	int ck_cnt = 0;
	logic [8:0] exp_q[$];
	logic [7:0] ra[5] = '{`OFS_STAT, `OFS_BAUD, `OFS_CTL_A, `OFS_CTL_B, 8'h20};
	logic [31:0] rv[5] = '{32'h3, 32'h10, 32'h0, 32'h0, 32'h0};
	// Clock of 5 ns.
	always #2.5 clk = ~clk;
	// Counts every pulse on the clock output, so each format case can compare a difference.
	always @(posedge sclk) ck_cnt <= ck_cnt + 1;
	serial_transmit_frame_baud i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.tx_line(tx_line), .serial_clock_out(sclk), .tx_complete_irq(irq));
	serial_rx_partner i_rx (.clk(clk), .tx_line(tx_line), .p(p), .nine(nine),
		.word(word), .cnt(rx_cnt), .gap(gap));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		q = rdata;
	endtask
	task automatic poll(input int b, input logic v);
		logic [31:0] q;
		q = {32{~v}};
		for (int n = 0; q[b] !== v; n++)
		begin
			acc(1'b0, `OFS_STAT, 32'h0, q);
			if (n > 2000)
			begin
				chk(32'h0, 32'h1, "status wait");
				end_sim;
			end
		end
	endtask
	task automatic rx_chk(input string what);
		int seen;
		seen = rx_cnt;
		for (int n = 0; rx_cnt == seen; n++)
		begin
			@(posedge clk);
			if (n > 4000)
			begin
				chk(32'h0, 32'h1, "frame wait");
				end_sim;
			end
		end
		chk({23'h0, word}, {23'h0, exp_q.pop_front()}, what);
	endtask
	function automatic logic [8:0] frame(input logic [8:0] d, input logic [3:0] c);
		logic [8:0] w;
		logic [8:0] r;
		int n;
		n = c[0] ? 9 : 8;
		w = c[0] ? d : {1'b0, d[7:0]};
		if (c[1])
			w[n - 1] = ^(w & ((9'h1 << (n - 1)) - 9'h1)) ^ c[2];
		r = w;
		if (c[3])
			for (int k = 0; k < n; k++)
				r[k] = w[n - 1 - k];
		return r;
	endfunction
	function automatic int stopc(input logic [1:0] s, input int q);
		case (s)
			`STB_ONE: return q;
			`STB_HALF: return q / 2;
			`STB_TWO: return 2 * q;
			default: return q + q / 2;
		endcase
	endfunction
	// Main sequence: reset values, idle frame, all formats, break, clearing.
	initial
	begin
		logic [31:0] q;
		logic [8:0] d;
		logic [3:0] c;
		logic [1:0] s;
		int b;
		int ck_base;
		q = $urandom(32'hdc59c60b);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		acc(1'b1, 8'h20, 32'hff, q);
		foreach (ra[i])
		begin
			acc(1'b0, ra[i], 32'h0, q);
			chk(q, rv[i], "reset value");
		end
		b = 16 + $urandom_range(15);
		p <= 6'(b);
		acc(1'b1, `OFS_BAUD, 32'(b), q);
		acc(1'b1, `OFS_CTL_A, 32'h38, q);
		repeat (4) @(posedge clk);
		acc(1'b0, `OFS_STAT, 32'h0, q);
		chk(q[`ST_BUSY], 1'b1, "idle frame busy");
		poll(`ST_BUSY, 1'b0);
		chk(rx_cnt, 0, "idle frame low bits");
		$display("test idle done");
		for (int i = 0; i < 16; i++)
		begin
			c = 4'(i);
			ck_base = ck_cnt;
			s = c[3:2] ^ c[1:0];
			nine <= c[0];
			acc(1'b1, `OFS_CTL_B, {29'h0, c[0], s}, q);
			acc(1'b1, `OFS_CTL_A, {25'h0, c[3], 3'h7, c[2:0]}, q);
			repeat (2)
			begin
				d = 9'($urandom);
				exp_q.push_back(frame(d, c));
				acc(1'b1, `OFS_DATA, {23'h0, d}, q);
				repeat (4) @(posedge clk);
			end
			rx_chk("word");
			rx_chk("word");
			chk(gap, (c[0] ? 10 : 9) * b + stopc(s, b) + 1, "frame gap");
			poll(`ST_TC, 1'b1);
			chk(irq, 1'b1, "irq");
			chk(ck_cnt - ck_base, c[0] ? 18 : 0, "clock pulses");
		end
		$display("test formats done");
		nine <= 1'b0;
		acc(1'b1, `OFS_CTL_A, 32'hb8, q);
		exp_q.push_back(9'h0);
		rx_chk("break");
		acc(1'b0, `OFS_CTL_A, 32'h0, q);
		chk(q, 32'h38, "break clear");
		poll(`ST_TC, 1'b1);
		exp_q.push_back(frame(9'h5a, 4'h0));
		bus <= '{addr: `OFS_DATA, wdata: 32'h5a, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: `OFS_STAT, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		chk(rdata[1:0], 2'h0, "flags after write");
		rx_chk("word");
		poll(`ST_TC, 1'b1);
		acc(1'b1, `OFS_CTL_C, 32'h1, q);
		acc(1'b1, `OFS_STAT, 32'h0, q);
		acc(1'b0, `OFS_STAT, 32'h0, q);
		chk(q[`ST_TC], 1'b0, "zero write clear");
		chk(irq, 1'b0, "irq low");
		acc(1'b1, `OFS_CTL_A, 32'h0, q);
		repeat (4) @(posedge clk);
		chk(tx_line, 1'b1, "line high");
		$display("test break and clear done");
		end_sim;
	end
endmodule
`default_nettype wire

/* verilog/serial_transmit_frame_baud.sv */
// Transmit side of an asynchronous serial transceiver: registers, baud divider,
// frame engine, one-word transmit buffer and its flags.
// Assumes a plain register port whose strobes last one cycle and one clock domain.
//
// Functional notes
// - Frame is start bit, data bits, then configured stop bits.
// - Word length selects 8 or 9 data bits.
// - With parity on, last data position (bit 7 or 8) holds parity.
// - Parity is even or odd by setting; none when parity is off.
// - Stop code 00 one, 01 half, 10 two, 11 one and a half bits.
// - Idle frame is all high and as long as a normal frame.
// - Break frame is low bit periods followed by configured stop bits.
// - Baud divider is 12-bit integer plus 4-bit sixteenths fraction.
// - Bit period equals sixteen times divider in clock cycles, never below 16 cycles.
// - Data bits go out least or most significant first, as set.
// - Enabled transmitter shifts buffered data out, optionally with clock pulses.
// - Line stays high while enabled with nothing to send.
// - Setting transmit enable sends one idle frame first.
// - Buffer empty flag: set at reset, cleared by write, set on load.
// - Word waits while shifting; moves at once when line is idle.
// - Complete flag sets when frame ends with buffer empty; may interrupt.
// - Complete clears on status read then data write, or zero write with DMA.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`include "serial_tx_cfg.svh"
`default_nettype none
module serial_transmit_frame_baud (
	input wire logic clk,
	input wire logic rst,
	input wire serial_tx_pkg::bus_req_s bus,
	output logic [31:0] rdata,
	output logic tx_line,
	output logic serial_clock_out,
	output logic tx_complete_irq
);
	import serial_tx_pkg::*;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [`CA_W-1:0] ctl_a, next_ctl_a;
	logic [`CB_W-1:0] ctl_b, next_ctl_b;
	logic tx_dma_enable, next_tx_dma_enable;
	logic [15:0] baud_divider, next_baud_divider;
	logic [31:0] next_rdata;
	logic tx_buffer_empty_flag;
	logic tx_complete_flag;
	logic brk_pend;
	tx_state_e state;
	logic wr_ctl_a, wr_data, wr_stat, rd_stat;
	frame_cfg_s fcfg;

	// Address decode of the one-cycle strobes.
	assign wr_ctl_a = bus.wr && (bus.addr == `OFS_CTL_A);
	assign wr_data = bus.wr && (bus.addr == `OFS_DATA);
	assign wr_stat = bus.wr && (bus.addr == `OFS_STAT);
	assign rd_stat = bus.rd && (bus.addr == `OFS_STAT);

	// Live frame settings steer the engine.
	assign fcfg = '{
		word_length_sel: ctl_a[`CA_WL],
		parity_enable: ctl_a[`CA_PARITY_ENABLE],
		parity_odd_sel: ctl_a[`CA_PODD],
		msb_first: ctl_a[`CA_MSBF]
	};

	// Register writes and the read data of the next cycle; unmapped reads give zero.
	always_comb
	begin
		next_ctl_a = ctl_a;
		next_ctl_b = ctl_b;
		next_tx_dma_enable = tx_dma_enable;
		next_baud_divider = baud_divider;
		next_rdata = 32'h0;
		if (bus.wr)
		begin
			unique case (bus.addr)
				`OFS_CTL_A: next_ctl_a = bus.wdata[`CA_W-1:0];
				`OFS_CTL_B: next_ctl_b = bus.wdata[`CB_W-1:0];
				`OFS_CTL_C: next_tx_dma_enable = bus.wdata[`CC_TX_DMA_ENABLE];
				`OFS_BAUD: next_baud_divider = bus.wdata[15:0];
				default: ;
			endcase
		end
		// The break request bit is a trigger and is held by the engine.
		next_ctl_a[`CA_BRK] = 1'b0;
		if (bus.rd)
		begin
			unique case (bus.addr)
				`OFS_CTL_A:
				begin
					next_rdata[`CA_W-1:0] = ctl_a;
					next_rdata[`CA_BRK] = brk_pend;
				end
				`OFS_CTL_B: next_rdata[`CB_W-1:0] = ctl_b;
				`OFS_CTL_C: next_rdata[`CC_TX_DMA_ENABLE] = tx_dma_enable;
				`OFS_BAUD: next_rdata[15:0] = baud_divider;
				`OFS_STAT:
				begin
					next_rdata[`ST_TBE] = tx_buffer_empty_flag;
					next_rdata[`ST_TC] = tx_complete_flag;
					next_rdata[`ST_BUSY] = (state != st_off) && (state != st_wait);
				end
				default: ;
			endcase
		end
	end

	// Register storage.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_a <= `CA_RST;
			ctl_b <= `CB_RST;
			tx_dma_enable <= 1'b0;
			baud_divider <= `BAUD_RST;
			rdata <= 32'h0;
		end
		else
		begin
			ctl_a <= next_ctl_a;
			ctl_b <= next_ctl_b;
			tx_dma_enable <= next_tx_dma_enable;
			baud_divider <= next_baud_divider;
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Frame word builder
	// ----------------------------------------------------------------
	// Inserts parity and reorders bits so the engine always shifts bit 0 first.
	function automatic logic [8:0] build_word(input logic [8:0] d, input frame_cfg_s c);
		logic [8:0] w;
		logic [8:0] r;
		logic par;
		w = c.word_length_sel ? d : {1'b0, d[7:0]};
		par = c.word_length_sel ? ^d[7:0] : ^d[6:0];
		if (c.parity_enable)
		begin
			if (c.word_length_sel)
				w[8] = par ^ c.parity_odd_sel;
			else
				w[7] = par ^ c.parity_odd_sel;
		end
		r = 9'h0;
		for (int i = 0; i < 9; i++)
		begin
			if (c.word_length_sel)
				r[i] = w[8-i];
			else if (i < 8)
				r[i] = w[7-i];
		end
		build_word = c.msb_first ? r : w;
	endfunction

	// ----------------------------------------------------------------
	// Transmit engine
	// ----------------------------------------------------------------
	tx_state_e next_state;
	frame_kind_e kind, next_kind;
	logic [17:0] cnt, next_cnt;
	logic [3:0] nbits, next_nbits;
	logic [8:0] shifter, next_shifter;
	logic [8:0] tx_buf, next_tx_buf;
	logic next_tbe, next_tc, next_brk_pend;
	logic idle_pend, next_idle_pend;
	logic ten_q, stat_seen, next_stat_seen;
	logic next_tx_line, next_serial_clock_out;
	logic enabled;
	logic [17:0] period, stop_cyc;
	logic [3:0] width;

	assign enabled = ctl_a[`CA_TEN] && ctl_a[`CA_UEN];
	assign width = fcfg.word_length_sel ? 4'h9 : 4'h8;
	// The raw divider already counts cycles: sixteen times int.frac.
	assign period = ({2'h0, baud_divider} < `MIN_PERIOD) ? `MIN_PERIOD
		: {2'h0, baud_divider};
	assign tx_complete_irq = tx_complete_flag && ctl_a[`CA_TX_COMPLETE_IRQ_EN];

	// Stop length in cycles by the two-bit selector.
	always_comb
	begin
		unique case (ctl_b[`CB_STB_LO +: 2])
			`STB_ONE: stop_cyc = period;
			`STB_HALF: stop_cyc = {1'b0, period[17:1]};
			`STB_TWO: stop_cyc = {period[16:0], 1'b0};
			`STB_ONE_HALF: stop_cyc = period + {1'b0, period[17:1]};
		endcase
	end

	// Next state of the engine, buffer and flags.
	always_comb
	begin
		next_state = state;
		next_kind = kind;
		next_cnt = cnt;
		next_nbits = nbits;
		next_shifter = shifter;
		next_tx_buf = tx_buf;
		next_tbe = tx_buffer_empty_flag;
		next_tc = tx_complete_flag;
		next_brk_pend = brk_pend || (wr_ctl_a && bus.wdata[`CA_BRK]);
		next_idle_pend = idle_pend || (ctl_a[`CA_TEN] && !ten_q);
		next_stat_seen = stat_seen || rd_stat;
		unique case (state)
			st_off:
				if (enabled)
					next_state = st_wait;
			st_wait:
				if (!enabled)
					next_state = st_off;
				else if (idle_pend)
				begin
					next_idle_pend = 1'b0;
					next_kind = fk_idle;
					next_state = st_start;
					next_cnt = period;
				end
				else if (brk_pend)
				begin
					next_brk_pend = wr_ctl_a && bus.wdata[`CA_BRK];
					next_kind = fk_break;
					next_state = st_start;
					next_cnt = period;
				end
				else if (!tx_buffer_empty_flag)
				begin
					next_shifter = build_word(tx_buf, fcfg);
					next_tbe = 1'b1;
					next_kind = fk_normal;
					next_state = st_start;
					next_cnt = period;
				end
			st_start:
				if (cnt == 18'h1)
				begin
					next_state = st_data;
					next_cnt = period;
					next_nbits = width;
				end
				else
					next_cnt = cnt - 18'h1;
			st_data:
				if (cnt == 18'h1)
				begin
					next_shifter = {1'b0, shifter[8:1]};
					next_nbits = nbits - 4'h1;
					next_cnt = (nbits == 4'h1) ? stop_cyc : period;
					if (nbits == 4'h1)
						next_state = st_stop;
				end
				else
					next_cnt = cnt - 18'h1;
			st_stop:
				if (cnt == 18'h1)
					next_state = st_wait;
				else
					next_cnt = cnt - 18'h1;
			default:
				next_state = st_off;
		endcase
		// Complete clears by status read then data write, or zero write under DMA.
		if (wr_data && stat_seen)
			next_tc = 1'b0;
		if (wr_stat && tx_dma_enable && !bus.wdata[`ST_TC])
			next_tc = 1'b0;
		if (wr_data)
		begin
			next_tx_buf = bus.wdata[8:0];
			next_tbe = 1'b0;
			next_stat_seen = 1'b0;
		end
		// Frame end sets complete and wins over a clear in the same cycle.
		if (state == st_stop && cnt == 18'h1 && next_tbe)
			next_tc = 1'b1;
		if (!ctl_a[`CA_TEN])
			next_idle_pend = 1'b0;
		// Line level follows the bit being sent; high whenever no bit is due.
		unique case (next_state)
			st_start: next_tx_line = (next_kind == fk_idle);
			st_data: next_tx_line = (next_kind == fk_normal) ? next_shifter[0]
				: (next_kind == fk_idle);
			default: next_tx_line = 1'b1;
		endcase
		// Clock pulse in the second half of each data bit when enabled.
		next_serial_clock_out = ctl_b[`CB_CKEN] && (next_state == st_data)
			&& (next_cnt <= {1'b0, period[17:1]});
	end

	// Engine storage.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= st_off;
			kind <= fk_normal;
			cnt <= 18'h0;
			nbits <= 4'h0;
			shifter <= 9'h0;
			tx_buf <= 9'h0;
			tx_buffer_empty_flag <= 1'b1;
			tx_complete_flag <= `TC_RST;
			brk_pend <= 1'b0;
			idle_pend <= 1'b0;
			ten_q <= 1'b0;
			stat_seen <= 1'b0;
			tx_line <= 1'b1;
			serial_clock_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			cnt <= next_cnt;
			nbits <= next_nbits;
			shifter <= next_shifter;
			tx_buf <= next_tx_buf;
			tx_buffer_empty_flag <= next_tbe;
			tx_complete_flag <= next_tc;
			brk_pend <= next_brk_pend;
			idle_pend <= next_idle_pend;
			ten_q <= ctl_a[`CA_TEN];
			stat_seen <= next_stat_seen;
			tx_line <= next_tx_line;
			serial_clock_out <= next_serial_clock_out;
		end
	end
endmodule
`default_nettype wire

/* verilog/serial_tx_cfg.svh */
// Register offsets, field positions and reset values of the serial transmitter.
// Assumes a byte-addressed plain register port with 32-bit data.
`ifndef SERIAL_TX_CFG_SVH
`define SERIAL_TX_CFG_SVH
`define OFS_CTL_A 8'h00
`define OFS_CTL_B 8'h04
`define OFS_CTL_C 8'h08
`define OFS_BAUD 8'h0c
`define OFS_STAT 8'h10
`define OFS_DATA 8'h14
`define CA_WL 0
`define CA_PARITY_ENABLE 1
`define CA_PODD 2
`define CA_TEN 3
`define CA_UEN 4
`define CA_TX_COMPLETE_IRQ_EN 5
`define CA_MSBF 6
`define CA_BRK 7
`define CA_W 8
`define CB_STB_LO 0
`define CB_CKEN 2
`define CB_W 3
`define CC_TX_DMA_ENABLE 0
`define ST_TBE 0
`define ST_TC 1
`define ST_BUSY 2
`define CA_RST 8'h00
`define CB_RST 3'h0
`define BAUD_RST 16'h0010
`define TC_RST 1'b1
`define MIN_PERIOD 18'h00010
`define STB_ONE 2'h0
`define STB_HALF 2'h1
`define STB_TWO 2'h2
`define STB_ONE_HALF 2'h3
`endif

/* verilog/serial_tx_pkg.sv */
// Types shared by the serial transmitter and its bench.
// Assumes serial_tx_cfg.svh for every register constant; state and frame kind codes are set here.
`default_nettype none
package serial_tx_pkg;
	typedef enum logic [2:0] {
		st_off = 3'h0,
		st_wait = 3'h1,
		st_start = 3'h2,
		st_data = 3'h3,
		st_stop = 3'h4
	} tx_state_e;
	typedef enum logic [1:0] {
		fk_normal = 2'h0,
		fk_idle = 2'h1,
		fk_break = 2'h2
	} frame_kind_e;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed {
		logic word_length_sel;
		logic parity_enable;
		logic parity_odd_sel;
		logic msb_first;
	} frame_cfg_s;
endpackage
`default_nettype wire
